// *** verilog/vmem_regs.svh ***
// Purpose: Port addresses, register indices, field positions, resets and timing
// Assumes: Included by the planar video memory design and its bench
// Notes: Definitions only
`ifndef VMEM_REGS_SVH
`define VMEM_REGS_SVH

// Fixed I/O ports
`define PORT_ATTR_INDEX 16'h03c0
`define PORT_ATTR_READ 16'h03c1
`define PORT_MISC_WRITE 16'h03c2
`define PORT_STATUS0 16'h03c2
`define PORT_SEQ_INDEX 16'h03c4
`define PORT_SEQ_DATA 16'h03c5
`define PORT_PIXEL_MASK 16'h03c6
`define PORT_LK_READ_INDEX 16'h03c7
`define PORT_LK_WRITE_INDEX 16'h03c8
`define PORT_LK_DATA 16'h03c9
`define PORT_FEATURE_READ 16'h03ca
`define PORT_MISC_READ 16'h03cc
`define PORT_GFX_INDEX 16'h03ce
`define PORT_GFX_DATA 16'h03cf
// Movable ports: upper twelve bits per range, low nibble per port
`define PORT_MONO_HI 12'h03b
`define PORT_COLOR_HI 12'h03d
`define PORT_CRT_INDEX_LO 4'h4
`define PORT_CRT_DATA_LO 4'h5
`define PORT_STATUS1_LO 4'ha

// Indexed register counts and indices
`define SEQ_COUNT 5
`define SEQ_MAP_MASK 3'h2
`define SEQ_MEM_MODE 3'h4
`define GFX_COUNT 9
`define GFX_COLOR_CMP 4'h2
`define GFX_READ_MAP 4'h4
`define GFX_MODE 4'h5
`define GFX_MISC 4'h6
`define GFX_DONT_CARE 4'h7
`define ATTR_COUNT 21
`define ATTR_MODE 5'h10
`define ATTR_PLANE_EN 5'h12
`define CRT_COUNT 25

// Field positions
`define MISC_IO_RANGE_SELECT 0
`define MISC_BUFFER_DECODE_ENABLE 1
`define MMODE_CHAIN4 3
`define GMODE_READ_MODE 3
`define GMODE_PACKED256 6
`define GMISC_WINDOW_LO 2
`define AMODE_MONO 1

// Reset values
`define MISC_RESET 8'h00
`define MAP_MASK_RESET 8'h0f
`define PIXEL_MASK_RESET 8'hff
`define PLANE_EN_RESET 8'h0f

// Host windows
`define WIN_A_BASE 20'ha0000
`define WIN_B_BASE 20'hb0000
`define WIN_C_BASE 20'hb8000
`define WIN_LARGE_SPAN 20'h10000
`define WIN_SMALL_SPAN 20'h08000

// Lookup indices for fixed colours, and the idle I/O read value
`define LK_BLACK 8'h00
`define LK_WHITE 8'h07
`define LK_WHITE_HI 8'h0f
`define IO_IDLE_READ 8'hff

// Timing
`define CLK_MHZ 250
`define BLINK_HALF_MS 250
`define BLINK_CYCLES (`BLINK_HALF_MS * 1000 * `CLK_MHZ)

`endif

// *** verilog/vmem_pkg.sv ***
// Purpose: Types shared by the planar video memory design and its bench
// Assumes: Nothing
// Notes: Constants live in vmem_regs.svh
package vmem_pkg;
	typedef struct packed {
		logic [15:0] addr;
		logic rd;
		logic wr;
		logic [7:0] data;
	} io_req_t;

	typedef struct packed {
		logic [19:0] addr;
		logic rd;
		logic wr;
		logic [7:0] data;
	} mem_req_t;

	typedef enum logic [1:0] {FMT_PLANAR16, FMT_MONO, FMT_TWO, FMT_PACKED256} disp_fmt_t;
endpackage

// *** verilog/planar_video_memory_access.sv ***
// Purpose: Display memory, host windows, I/O register groups and pixel formation
// Assumes: One host access per cycle; display fetches come from the CRT timing logic
// Notes: Memory read/write is answered one cycle after the request
// What this block does
// - Monochrome emulation takes video from map 0, intensity from map 2.
// - Monochrome pixel: 00 black, 01 white, 10 blinking white, 11 bright white.
// - Planar modes emit eight pixels per byte, most significant bit first.
// - Two-colour pixel zero is black, one is intensified white.
// - Two-colour mode reads map 0 only, eight pixels per byte.
// - Sixteen-colour modes take planes 0..3 as blue, green, red, intensity.
// - Sixteen-colour plane bits index the internal palette.
// - 256-colour mode is a linear one byte per pixel buffer.
// - 256-colour mode takes each eight-bit lookup address whole from one map byte.
// - Each lookup entry holds an 18-bit colour.
// - Storage is four independently enabled 64KB maps.
// - Host window is 64KB at A0000, or 32KB at B0000 or B8000.
// - A write enables a map only if decode and map mask agree.
// - Read mode 0 returns the decoded byte, using read map select, or address bits 1:0 in chain 4.
// - Read mode 1 returns per-pixel colour compare under the ignore mask.
// - All registers read back except data latches, attribute toggle and lookup read index.
// - CRT ports and status 1 sit in 3Bx or 3Dx by range select.
// - Decode sequencer, graphics, attribute and lookup index/data ports.
// - Miscellaneous bit 0 picks 3Bx or 3Dx for CRT and status 1.
// - Miscellaneous bit 1 clear ignores host buffer accesses; display fetches still read the maps.
`include "vmem_regs.svh"
module planar_video_memory_access
	import vmem_pkg::*;
#(
	parameter int BLINK_CYCLES = `BLINK_CYCLES
)(
	input wire logic mclk_in,
	input wire logic reset_in,
	input wire io_req_t io_req_in,
	output logic [7:0] io_rdata_out,
	output logic io_ack_out,
	input wire mem_req_t mem_req_in,
	output logic [7:0] mem_rdata_out,
	output logic mem_ack_out,
	input wire logic disp_fetch_in,
	input wire logic [15:0] disp_offset_in,
	output logic disp_ready_out,
	output logic pixel_valid_out,
	output logic [7:0] lookup_index_out,
	output logic [17:0] colour_out
);
	typedef enum logic {DISP_IDLE, DISP_SHIFT} disp_state_t;

	logic [7:0] map_mem [0:3][0:65535];
	logic [17:0] lookup_mem [0:255];
	logic [7:0] seq_q [0:`SEQ_COUNT-1];
	logic [7:0] gfx_q [0:`GFX_COUNT-1];
	logic [7:0] attr_q [0:`ATTR_COUNT-1];
	logic [7:0] crt_q [0:`CRT_COUNT-1];
	logic [7:0] misc_q, pixel_mask_q, feature_q;
	logic [2:0] seq_index_q;
	logic [3:0] gfx_index_q;
	logic [5:0] attr_index_q;
	logic [4:0] crt_index_q;
	logic attr_toggle_q;
	logic [7:0] lk_wr_index_q, lk_rd_index_q;
	logic [1:0] lk_wr_comp_q, lk_rd_comp_q;
	logic [11:0] lk_hold_q;
	disp_state_t disp_state_q;
	logic [7:0] shift_q [0:3];
	logic [2:0] shift_cnt_q;
	disp_fmt_t fmt_q;
	logic blink_q;
	logic [31:0] blink_cnt_q;
	logic pix_valid_q;

	// Host memory decode
	logic [19:0] win_base, win_span, win_rel;
	logic win_hit, chain4;
	logic [15:0] mem_offset;
	logic [3:0] map_wr_en;
	logic [1:0] read_plane;
	logic [7:0] compare_byte;

	always_comb
	begin
		case (gfx_q[`GFX_MISC][`GMISC_WINDOW_LO +: 2])
			2'b10:
			begin
				win_base = `WIN_B_BASE;
				win_span = `WIN_SMALL_SPAN;
			end
			2'b11:
			begin
				win_base = `WIN_C_BASE;
				win_span = `WIN_SMALL_SPAN;
			end
			default:
			begin
				win_base = `WIN_A_BASE;
				win_span = `WIN_LARGE_SPAN;
			end
		endcase
		win_rel = mem_req_in.addr - win_base;
		win_hit = (mem_req_in.addr >= win_base) && (win_rel < win_span)
			&& misc_q[`MISC_BUFFER_DECODE_ENABLE];
		chain4 = seq_q[`SEQ_MEM_MODE][`MMODE_CHAIN4];
		// Chain 4 spreads consecutive bytes over the four maps
		mem_offset = chain4 ? {2'b00, win_rel[15:2]} : win_rel[15:0];
		for (int p = 0; p < 4; p++)
		begin
			map_wr_en[p] = win_hit && mem_req_in.wr && seq_q[`SEQ_MAP_MASK][p]
				&& (!chain4 || win_rel[1:0] == 2'(p));
		end
		read_plane = chain4 ? win_rel[1:0] : gfx_q[`GFX_READ_MAP][1:0];
		for (int b = 0; b < 8; b++)
		begin
			compare_byte[b] = 1'b1;
			for (int p = 0; p < 4; p++)
			begin
				if (gfx_q[`GFX_DONT_CARE][p]
					&& map_mem[p][mem_offset][b] != gfx_q[`GFX_COLOR_CMP][p])
					compare_byte[b] = 1'b0;
			end
		end
	end

	// Display storage, one write port per map
	always_ff @(posedge mclk_in)
	begin
		for (int p = 0; p < 4; p++)
		begin
			if (map_wr_en[p])
				map_mem[p][mem_offset] <= mem_req_in.data;
		end
	end

	always_ff @(posedge mclk_in)
	begin
		if (reset_in)
		begin
			mem_ack_out <= 1'b0;
			mem_rdata_out <= 8'h00;
		end
		else
		begin
			mem_ack_out <= win_hit && (mem_req_in.rd || mem_req_in.wr);
			if (win_hit && mem_req_in.rd)
			begin
				if (gfx_q[`GFX_MODE][`GMODE_READ_MODE])
					mem_rdata_out <= compare_byte;
				else
					mem_rdata_out <= map_mem[read_plane][mem_offset];
			end
		end
	end

	// I/O decode
	logic io_crt_hi, io_crt_index, io_crt_data, io_status1;
	always_comb
	begin
		io_crt_hi = io_req_in.addr[15:4] == (misc_q[`MISC_IO_RANGE_SELECT] ?
			`PORT_COLOR_HI : `PORT_MONO_HI);
		io_crt_index = io_crt_hi && io_req_in.addr[3:0] == `PORT_CRT_INDEX_LO;
		io_crt_data = io_crt_hi && io_req_in.addr[3:0] == `PORT_CRT_DATA_LO;
		io_status1 = io_crt_hi && io_req_in.addr[3:0] == `PORT_STATUS1_LO;
	end

	// Register writes for general, sequencer, graphics and CRT groups
	always_ff @(posedge mclk_in)
	begin
		if (reset_in)
		begin
			misc_q <= `MISC_RESET;
			feature_q <= 8'h00;
			pixel_mask_q <= `PIXEL_MASK_RESET;
			seq_index_q <= 3'h0;
			gfx_index_q <= 4'h0;
			crt_index_q <= 5'h00;
			for (int i = 0; i < `SEQ_COUNT; i++)
				seq_q[i] <= 8'h00;
			seq_q[`SEQ_MAP_MASK] <= `MAP_MASK_RESET;
			for (int i = 0; i < `GFX_COUNT; i++)
				gfx_q[i] <= 8'h00;
			for (int i = 0; i < `CRT_COUNT; i++)
				crt_q[i] <= 8'h00;
		end
		else if (io_req_in.wr)
		begin
			case (io_req_in.addr)
				`PORT_MISC_WRITE: misc_q <= io_req_in.data;
				`PORT_SEQ_INDEX: seq_index_q <= io_req_in.data[2:0];
				`PORT_SEQ_DATA:
					if (seq_index_q < 3'(`SEQ_COUNT))
						seq_q[seq_index_q] <= io_req_in.data;
				`PORT_PIXEL_MASK: pixel_mask_q <= io_req_in.data;
				`PORT_GFX_INDEX: gfx_index_q <= io_req_in.data[3:0];
				`PORT_GFX_DATA:
					if (gfx_index_q < 4'(`GFX_COUNT))
						gfx_q[gfx_index_q] <= io_req_in.data;
				default:
				begin
					if (io_crt_index)
						crt_index_q <= io_req_in.data[4:0];
					else if (io_crt_data && crt_index_q < 5'(`CRT_COUNT))
						crt_q[crt_index_q] <= io_req_in.data;
					else if (io_status1)
						feature_q <= io_req_in.data;
				end
			endcase
		end
	end

	// Attribute group: one port alternates index and data
	always_ff @(posedge mclk_in)
	begin
		if (reset_in)
		begin
			attr_toggle_q <= 1'b0;
			attr_index_q <= 6'h00;
			for (int i = 0; i < `ATTR_COUNT; i++)
				attr_q[i] <= 8'h00;
			attr_q[`ATTR_PLANE_EN] <= `PLANE_EN_RESET;
		end
		else if (io_req_in.wr && io_req_in.addr == `PORT_ATTR_INDEX)
		begin
			attr_toggle_q <= !attr_toggle_q;
			if (!attr_toggle_q)
				attr_index_q <= io_req_in.data[5:0];
			else if (attr_index_q[4:0] < 5'(`ATTR_COUNT))
				attr_q[attr_index_q[4:0]] <= io_req_in.data;
		end
		else if (io_req_in.rd && io_status1)
			attr_toggle_q <= 1'b0;
	end

	// Colour lookup: red, green, blue bytes per entry
	always_ff @(posedge mclk_in)
	begin
		if (reset_in)
		begin
			lk_wr_index_q <= 8'h00;
			lk_rd_index_q <= 8'h00;
			lk_wr_comp_q <= 2'd0;
			lk_rd_comp_q <= 2'd0;
			lk_hold_q <= 12'h000;
		end
		else if (io_req_in.wr)
		begin
			case (io_req_in.addr)
				`PORT_LK_WRITE_INDEX:
				begin
					lk_wr_index_q <= io_req_in.data;
					lk_wr_comp_q <= 2'd0;
				end
				`PORT_LK_READ_INDEX:
				begin
					lk_rd_index_q <= io_req_in.data;
					lk_rd_comp_q <= 2'd0;
				end
				`PORT_LK_DATA:
				begin
					if (lk_wr_comp_q == 2'd2)
					begin
						lk_wr_comp_q <= 2'd0;
						lk_wr_index_q <= lk_wr_index_q + 8'h01;
					end
					else
					begin
						lk_wr_comp_q <= lk_wr_comp_q + 2'd1;
						lk_hold_q <= {lk_hold_q[5:0], io_req_in.data[5:0]};
					end
				end
				default:
				begin
				end
			endcase
		end
		else if (io_req_in.rd && io_req_in.addr == `PORT_LK_DATA)
		begin
			if (lk_rd_comp_q == 2'd2)
			begin
				lk_rd_comp_q <= 2'd0;
				lk_rd_index_q <= lk_rd_index_q + 8'h01;
			end
			else
				lk_rd_comp_q <= lk_rd_comp_q + 2'd1;
		end
	end

	always_ff @(posedge mclk_in)
	begin
		if (io_req_in.wr && io_req_in.addr == `PORT_LK_DATA && lk_wr_comp_q == 2'd2)
			lookup_mem[lk_wr_index_q] <= {lk_hold_q, io_req_in.data[5:0]};
	end

	// Register read-back
	logic [17:0] lk_rd_entry;
	logic [7:0] io_read;
	always_comb
	begin
		lk_rd_entry = lookup_mem[lk_rd_index_q];
		io_read = `IO_IDLE_READ;
		case (io_req_in.addr)
			`PORT_ATTR_INDEX: io_read = {2'b00, attr_index_q};
			`PORT_ATTR_READ:
				if (attr_index_q[4:0] < 5'(`ATTR_COUNT))
					io_read = attr_q[attr_index_q[4:0]];
			`PORT_STATUS0: io_read = 8'h00;
			`PORT_MISC_READ: io_read = misc_q;
			`PORT_FEATURE_READ: io_read = feature_q;
			`PORT_SEQ_INDEX: io_read = {5'h00, seq_index_q};
			`PORT_SEQ_DATA:
				if (seq_index_q < 3'(`SEQ_COUNT))
					io_read = seq_q[seq_index_q];
			`PORT_PIXEL_MASK: io_read = pixel_mask_q;
			`PORT_LK_READ_INDEX: io_read = 8'h00;
			`PORT_LK_WRITE_INDEX: io_read = lk_wr_index_q;
			`PORT_LK_DATA:
				case (lk_rd_comp_q)
					2'd0: io_read = {2'b00, lk_rd_entry[17:12]};
					2'd1: io_read = {2'b00, lk_rd_entry[11:6]};
					default: io_read = {2'b00, lk_rd_entry[5:0]};
				endcase
			`PORT_GFX_INDEX: io_read = {4'h0, gfx_index_q};
			`PORT_GFX_DATA:
				if (gfx_index_q < 4'(`GFX_COUNT))
					io_read = gfx_q[gfx_index_q];
			default:
			begin
				if (io_crt_index)
					io_read = {3'b000, crt_index_q};
				else if (io_crt_data && crt_index_q < 5'(`CRT_COUNT))
					io_read = crt_q[crt_index_q];
				else if (io_status1)
					io_read = {4'h0, disp_state_q == DISP_IDLE, 2'b00,
						disp_state_q == DISP_IDLE};
			end
		endcase
	end

	always_ff @(posedge mclk_in)
	begin
		if (reset_in)
		begin
			io_ack_out <= 1'b0;
			io_rdata_out <= 8'h00;
		end
		else
		begin
			io_ack_out <= io_req_in.rd || io_req_in.wr;
			if (io_req_in.rd)
				io_rdata_out <= io_read;
		end
	end

	// Blink phase for monochrome emulation
	always_ff @(posedge mclk_in)
	begin
		if (reset_in)
		begin
			blink_cnt_q <= 32'h0;
			blink_q <= 1'b0;
		end
		else if (blink_cnt_q == 32'(BLINK_CYCLES - 1))
		begin
			blink_cnt_q <= 32'h0;
			blink_q <= !blink_q;
		end
		else
			blink_cnt_q <= blink_cnt_q + 32'h1;
	end

	// Display format from mode registers
	disp_fmt_t fmt_now;
	always_comb
	begin
		if (gfx_q[`GFX_MODE][`GMODE_PACKED256])
			fmt_now = FMT_PACKED256;
		else if (attr_q[`ATTR_MODE][`AMODE_MONO])
			fmt_now = FMT_MONO;
		else if (attr_q[`ATTR_PLANE_EN][3:0] == 4'b0001)
			fmt_now = FMT_TWO;
		else
			fmt_now = FMT_PLANAR16;
	end

	// Fetch and serialise
	logic last_pixel;
	assign last_pixel = disp_state_q == DISP_SHIFT && shift_cnt_q == 3'd0;
	always_ff @(posedge mclk_in)
	begin
		if (reset_in)
		begin
			disp_state_q <= DISP_IDLE;
			shift_cnt_q <= 3'd0;
			fmt_q <= FMT_PLANAR16;
			for (int p = 0; p < 4; p++)
				shift_q[p] <= 8'h00;
		end
		else
		begin
			case (disp_state_q)
				DISP_IDLE:
					if (disp_fetch_in)
						disp_state_q <= DISP_SHIFT;
				DISP_SHIFT:
					if (last_pixel && !disp_fetch_in)
						disp_state_q <= DISP_IDLE;
				default: disp_state_q <= DISP_IDLE;
			endcase
			if (disp_fetch_in && (disp_state_q == DISP_IDLE || last_pixel))
			begin
				for (int p = 0; p < 4; p++)
					shift_q[p] <= map_mem[p][disp_offset_in];
				fmt_q <= fmt_now;
				shift_cnt_q <= fmt_now == FMT_PACKED256 ? 3'd3 : 3'd7;
			end
			else if (disp_state_q == DISP_SHIFT)
			begin
				shift_cnt_q <= shift_cnt_q - 3'd1;
				if (fmt_q == FMT_PACKED256)
				begin
					shift_q[0] <= shift_q[1];
					shift_q[1] <= shift_q[2];
					shift_q[2] <= shift_q[3];
				end
				else
				begin
					for (int p = 0; p < 4; p++)
						shift_q[p] <= {shift_q[p][6:0], 1'b0};
				end
			end
		end
	end

	// Pixel formation
	logic [3:0] plane_bits;
	logic [7:0] pixel_index;
	always_comb
	begin
		plane_bits = {shift_q[3][7], shift_q[2][7], shift_q[1][7], shift_q[0][7]};
		case (fmt_q)
			FMT_MONO:
				case ({plane_bits[2], plane_bits[0]})
					2'b00: pixel_index = `LK_BLACK;
					2'b01: pixel_index = `LK_WHITE;
					2'b10: pixel_index = blink_q ? `LK_WHITE : `LK_BLACK;
					default: pixel_index = `LK_WHITE_HI;
				endcase
			FMT_TWO:
				pixel_index = plane_bits[0] ? `LK_WHITE_HI : `LK_BLACK;
			FMT_PACKED256:
				pixel_index = shift_q[0];
			default:
				pixel_index = {2'b00, attr_q[plane_bits & attr_q[`ATTR_PLANE_EN][3:0]][5:0]};
		endcase
	end

	always_ff @(posedge mclk_in)
	begin
		if (reset_in)
		begin
			pix_valid_q <= 1'b0;
			pixel_valid_out <= 1'b0;
			lookup_index_out <= 8'h00;
			colour_out <= 18'h00000;
			disp_ready_out <= 1'b0;
		end
		else
		begin
			disp_ready_out <= !(disp_state_q == DISP_SHIFT && shift_cnt_q > 3'd1)
				&& !(disp_fetch_in && !last_pixel);
			pix_valid_q <= disp_state_q == DISP_SHIFT;
			pixel_valid_out <= disp_state_q == DISP_SHIFT;
			if (disp_state_q == DISP_SHIFT)
				lookup_index_out <= pixel_index & pixel_mask_q;
			if (pix_valid_q)
				colour_out <= lookup_mem[lookup_index_out];
		end
	end
endmodule // planar_video_memory_access

// *** bench/planar_video_memory_access_monitor.sv ***
// Purpose: Port-level checks on host cycles and pixel output
// Assumes: Bound to the top module, one clock domain
// Notes: Tracks the decode enable bit from host writes
`include "vmem_regs.svh"
module planar_video_memory_access_monitor
	import vmem_pkg::*;
#(
	parameter int BLINK_CYCLES = 4
)(
	input wire logic mclk_in,
	input wire logic reset_in,
	input wire io_req_t io_req_in,
	input wire logic [7:0] io_rdata_out,
	input wire logic io_ack_out,
	input wire mem_req_t mem_req_in,
	input wire logic mem_ack_out,
	input wire logic disp_fetch_in,
	input wire logic disp_ready_out,
	input wire logic pixel_valid_out
);
	logic [7:0] misc_q;
	always_ff @(posedge mclk_in)
	begin
		if (reset_in)
			misc_q <= `MISC_RESET;
		else if (io_req_in.wr && io_req_in.addr == `PORT_MISC_WRITE)
			misc_q <= io_req_in.data;
	end
	default clocking @(posedge mclk_in); endclocking
	default disable iff (reset_in);
	sequence s_fetch;
		disp_fetch_in && disp_ready_out;
	endsequence
	sequence s_group;
		pixel_valid_out [*4];
	endsequence
	property p_disp_group;
		s_fetch |-> ##2 s_group;
	endproperty
	a_disp_group: assert property (p_disp_group) else $error("pixel group late");
	property p_disp_cause;
		$rose(pixel_valid_out) |-> $past(disp_fetch_in, 2);
	endproperty
	a_disp_cause: assert property (p_disp_cause) else $error("pixels without fetch");
	property p_io_ack;
		(io_req_in.rd || io_req_in.wr) |=> io_ack_out;
	endproperty
	a_io_ack: assert property (p_io_ack) else $error("io access not acked");
	property p_io_cause;
		io_ack_out |-> $past(io_req_in.rd || io_req_in.wr);
	endproperty
	a_io_cause: assert property (p_io_cause) else $error("io ack without access");
	property p_io_idle;
		io_req_in.rd && io_req_in.addr[15:8] != 8'h03 |=> io_rdata_out == `IO_IDLE_READ;
	endproperty
	a_io_idle: assert property (p_io_idle) else $error("unmapped read not idle");
	property p_io_hold;
		!io_req_in.rd |=> $stable(io_rdata_out);
	endproperty
	a_io_hold: assert property (p_io_hold) else $error("io read data moved");
	property p_mem_off;
		(mem_req_in.rd || mem_req_in.wr) && !misc_q[`MISC_BUFFER_DECODE_ENABLE] |=> !mem_ack_out;
	endproperty
	a_mem_off: assert property (p_mem_off) else $error("ack with decode off");
	property p_mem_out;
		(mem_req_in.rd || mem_req_in.wr) && (mem_req_in.addr < 20'ha0000
			|| mem_req_in.addr >= 20'hc0000) |=> !mem_ack_out;
	endproperty
	a_mem_out: assert property (p_mem_out) else $error("ack outside windows");
	property p_mem_cause;
		mem_ack_out |-> $past(mem_req_in.rd || mem_req_in.wr);
	endproperty
	a_mem_cause: assert property (p_mem_cause) else $error("mem ack without access");
endmodule // planar_video_memory_access_monitor

bind planar_video_memory_access planar_video_memory_access_monitor #(
	.BLINK_CYCLES(BLINK_CYCLES)
) mon (
	.mclk_in(mclk_in),
	.reset_in(reset_in),
	.io_req_in(io_req_in),
	.io_rdata_out(io_rdata_out),
	.io_ack_out(io_ack_out),
	.mem_req_in(mem_req_in),
	.mem_ack_out(mem_ack_out),
	.disp_fetch_in(disp_fetch_in),
	.disp_ready_out(disp_ready_out),
	.pixel_valid_out(pixel_valid_out)
);

// *** bench/host_bus_model.sv ***
// Purpose: Host model issuing I/O and memory byte cycles
// Assumes: One request per cycle, answer read just after the next edge
// Notes: Idle address and data lines show the inverse of the last request; read and write strobes drop to zero
module host_bus_model
	import vmem_pkg::*;
(
	input wire logic mclk_in,
	input wire logic io_ack_in,
	input wire logic [7:0] io_rdata_in,
	input wire logic mem_ack_in,
	input wire logic [7:0] mem_rdata_in,
	output io_req_t io_req_out,
	output mem_req_t mem_req_out
);
	timeunit 1ns;
	timeprecision 100ps;
	initial
	begin
		io_req_out = '0;
		mem_req_out = '0;
	end
	task automatic io_acc(input logic [15:0] a, input logic w, input logic [7:0] d,
		output logic ack, output logic [7:0] q);
		@(posedge mclk_in);
		io_req_out <= '{addr: a, rd: ~w, wr: w, data: d};
		@(posedge mclk_in);
		io_req_out <= '{addr: ~a, rd: 1'b0, wr: 1'b0, data: ~d};
		#1;
		ack = io_ack_in;
		q = io_rdata_in;
	endtask
	task automatic mem_acc(input logic [19:0] a, input logic w, input logic [7:0] d,
		output logic ack, output logic [7:0] q);
		@(posedge mclk_in);
		mem_req_out <= '{addr: a, rd: ~w, wr: w, data: d};
		@(posedge mclk_in);
		mem_req_out <= '{addr: ~a, rd: 1'b0, wr: 1'b0, data: ~d};
		#1;
		ack = mem_ack_in;
		q = mem_rdata_in;
	endtask
endmodule // host_bus_model

// *** bench/planar_video_memory_access_bench.sv ***
// Purpose: Self-checking bench for the planar video memory access block
// Assumes: Host model drives both request ports
// Notes: Expected pixels come from map bytes the bench wrote
`include "vmem_regs.svh"
module planar_video_memory_access_bench
	import vmem_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic mclk_in = 1'b0;
	logic reset_in = 1'b1;
	logic disp_fetch_in = 1'b0;
	logic [15:0] disp_offset_in = 16'h0000;
	io_req_t io_req;
	mem_req_t mem_req;
	logic [7:0] io_rdata, mem_rdata, lookup_index_out, q, c, dc;
	logic io_ack, mem_ack, disp_ready_out, pixel_valid_out, ack;
	logic [17:0] colour_out;
	logic [7:0] m [4];
	logic [17:0] lut [256];
	int fail_count = 0;
	int n_compared = 0;
	logic blink_ref = 1'b0, blink_seen;
	int blink_n = 0;
	always #2 mclk_in = ~mclk_in;
	// Blink phase for a half period of four cycles, seen one edge late
	always @(posedge mclk_in)
	begin
		blink_seen <= blink_ref;
		blink_n <= (reset_in || blink_n == 3) ? 0 : blink_n + 1;
		blink_ref <= reset_in ? 1'b0 : blink_ref ^ (blink_n == 3);
	end
	planar_video_memory_access #(.BLINK_CYCLES(4)) dut (.mclk_in(mclk_in), .reset_in(reset_in),
		.io_req_in(io_req), .io_rdata_out(io_rdata), .io_ack_out(io_ack),
		.mem_req_in(mem_req), .mem_rdata_out(mem_rdata), .mem_ack_out(mem_ack),
		.disp_fetch_in(disp_fetch_in), .disp_offset_in(disp_offset_in),
		.disp_ready_out(disp_ready_out), .pixel_valid_out(pixel_valid_out),
		.lookup_index_out(lookup_index_out), .colour_out(colour_out));
	host_bus_model host (.mclk_in(mclk_in), .io_ack_in(io_ack), .io_rdata_in(io_rdata),
		.mem_ack_in(mem_ack), .mem_rdata_in(mem_rdata), .io_req_out(io_req),
		.mem_req_out(mem_req));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_sim;
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic io(input logic [15:0] a, input logic w, input logic [7:0] d, e);
		host.io_acc(a, w, d, ack, q);
		check(ack, 1'b1);
		if (!w)
			check(q, e);
	endtask
	task automatic mem(input logic [19:0] a, input logic w, input logic [7:0] d,
		input logic ea, input logic [7:0] e);
		host.mem_acc(a, w, d, ack, q);
		check(ack, ea);
		if (!w && ea)
			check(q, e);
	endtask
	task automatic ix(input logic [15:0] p, input logic [7:0] i, d);
		io(p, 1'b1, i, 8'h00);
		io(p + 16'h0001, 1'b1, d, 8'h00);
	endtask
	task automatic attr_wr(input logic [7:0] i, d);
		host.io_acc(16'h03ba, 1'b0, 8'h00, ack, q);
		ix(`PORT_ATTR_INDEX - 16'h0001, 8'h00, i);
		io(`PORT_ATTR_INDEX, 1'b1, d, 8'h00);
		io(`PORT_ATTR_READ, 1'b0, 8'h00, d);
	endtask
	task automatic load_maps(input logic [19:0] off);
		for (int k = 0; k < 4; k++)
		begin
			ix(`PORT_SEQ_INDEX, {5'h00, `SEQ_MAP_MASK}, 8'h01 << k);
			mem(`WIN_A_BASE + off, 1'b1, m[k], 1'b1, 8'h00);
		end
		ix(`PORT_SEQ_INDEX, {5'h00, `SEQ_MAP_MASK}, 8'h0f);
	endtask
	function automatic logic [7:0] exp_pix(disp_fmt_t f, int k);
		logic [3:0] p;
		p = {m[3][7-k], m[2][7-k], m[1][7-k], m[0][7-k]};
		case (f)
			FMT_MONO: exp_pix = p[0] ? (p[2] ? `LK_WHITE_HI : `LK_WHITE)
				: (p[2] && blink_seen ? `LK_WHITE : `LK_BLACK);
			FMT_TWO: exp_pix = p[0] ? `LK_WHITE_HI : `LK_BLACK;
			FMT_PLANAR16: exp_pix = 8'h0f - {4'h0, p};
			default: exp_pix = m[k];
		endcase
	endfunction
	function automatic logic [7:0] cmp(logic [3:0] cc, logic [3:0] dcm);
		for (int b = 0; b < 8; b++)
			cmp[b] = &(~dcm | ~({m[3][b], m[2][b], m[1][b], m[0][b]} ^ cc));
	endfunction
	task automatic show(input logic [15:0] off, input int n, input disp_fmt_t f);
		int t;
		logic [7:0] prev;
		t = 0;
		while (disp_ready_out !== 1'b1 && t < 50)
		begin
			@(posedge mclk_in);
			#1;
			t++;
		end
		@(posedge mclk_in);
		disp_fetch_in <= 1'b1;
		disp_offset_in <= off;
		@(posedge mclk_in);
		disp_fetch_in <= 1'b0;
		disp_offset_in <= ~off;
		#1;
		t = 0;
		while (pixel_valid_out !== 1'b1 && t < 4)
		begin
			@(posedge mclk_in);
			#1;
			t++;
		end
		for (int k = 0; k <= n; k++)
		begin
			if (k < n)
			begin
				check(pixel_valid_out, 1'b1);
				check(lookup_index_out, exp_pix(f, k));
			end
			if (k > 0)
				check(colour_out, lut[prev]);
			prev = exp_pix(f, k);
			@(posedge mclk_in);
			#1;
		end
	endtask
	initial
	begin
		repeat (40000) @(posedge mclk_in);
		fail_count++;
		end_sim();
	end
	initial
	begin
		repeat (4) @(posedge mclk_in);
		reset_in <= 1'b0;
		void'($urandom(32'hf3dc));
		io(16'h1234, 1'b0, 8'h00, `IO_IDLE_READ);
		io(`PORT_MISC_READ, 1'b0, 8'h00, `MISC_RESET);
		io(`PORT_PIXEL_MASK, 1'b0, 8'h00, `PIXEL_MASK_RESET);
		mem(20'ha0030, 1'b1, 8'h22, 1'b0, 8'h00);
		host.io_acc(`PORT_MISC_READ, 1'b0, 8'h00, ack, q);
		io(`PORT_MISC_WRITE, 1'b1, q | 8'h02, 8'h00);
		mem(20'ha0030, 1'b1, 8'h11, 1'b1, 8'h00);
		mem(20'ha0030, 1'b0, 8'h00, 1'b1, 8'h11);
		io(`PORT_MISC_WRITE, 1'b1, 8'h00, 8'h00);
		mem(20'ha0030, 1'b1, 8'h22, 1'b0, 8'h00);
		io(`PORT_MISC_WRITE, 1'b1, 8'h02, 8'h00);
		ix(`PORT_GFX_INDEX, {4'h0, `GFX_MISC}, 8'h08);
		mem(20'ha0030, 1'b1, 8'h33, 1'b0, 8'h00);
		mem(20'hb7fff, 1'b1, 8'h44, 1'b1, 8'h00);
		mem(20'hb8000, 1'b1, 8'h44, 1'b0, 8'h00);
		ix(`PORT_GFX_INDEX, {4'h0, `GFX_MISC}, 8'h0c);
		mem(20'hb8000, 1'b1, 8'h55, 1'b1, 8'h00);
		mem(20'hb7fff, 1'b1, 8'h55, 1'b0, 8'h00);
		mem(20'hc0000, 1'b1, 8'h55, 1'b0, 8'h00);
		ix(`PORT_GFX_INDEX, {4'h0, `GFX_MISC}, 8'h00);
		mem(20'ha0030, 1'b0, 8'h00, 1'b1, 8'h11);
		mem(20'hb0000, 1'b1, 8'h66, 1'b0, 8'h00);
		mem(20'h9ffff, 1'b1, 8'h66, 1'b0, 8'h00);
		for (int i = 0; i < 14; i++)
		begin
			c = 8'($urandom);
			ix(i < 5 ? `PORT_SEQ_INDEX : `PORT_GFX_INDEX, 8'(i < 5 ? i : i - 5), c);
			io(i < 5 ? `PORT_SEQ_DATA : `PORT_GFX_DATA, 1'b0, 8'h00, c);
		end
		ix(`PORT_GFX_INDEX, 8'h09, 8'h5a);
		io(`PORT_GFX_DATA, 1'b0, 8'h00, `IO_IDLE_READ);
		for (int i = 0; i < 14; i++)
			ix(i < 5 ? `PORT_SEQ_INDEX : `PORT_GFX_INDEX, 8'(i < 5 ? i : i - 5),
				i == 2 ? 8'h0f : 8'h00);
		c = 8'($urandom);
		ix(16'h03b4, 8'h05, c);
		io(16'h03b5, 1'b0, 8'h00, c);
		io(`PORT_MISC_WRITE, 1'b1, 8'h03, 8'h00);
		io(16'h03d5, 1'b0, 8'h00, c);
		io(16'h03b5, 1'b0, 8'h00, `IO_IDLE_READ);
		io(`PORT_MISC_WRITE, 1'b1, 8'h02, 8'h00);
		for (int k = 0; k < 4; k++)
			m[k] = 8'($urandom);
		load_maps(20'h00010);
		for (int k = 0; k < 4; k++)
		begin
			ix(`PORT_GFX_INDEX, {4'h0, `GFX_READ_MAP}, 8'(k));
			mem(20'ha0010, 1'b0, 8'h00, 1'b1, m[k]);
		end
		ix(`PORT_SEQ_INDEX, {5'h00, `SEQ_MAP_MASK}, 8'h05);
		mem(20'ha0010, 1'b1, 8'hc3, 1'b1, 8'h00);
		m[0] = 8'hc3;
		m[2] = 8'hc3;
		ix(`PORT_SEQ_INDEX, {5'h00, `SEQ_MAP_MASK}, 8'h0f);
		for (int k = 0; k < 4; k++)
		begin
			ix(`PORT_GFX_INDEX, {4'h0, `GFX_READ_MAP}, 8'(k));
			mem(20'ha0010, 1'b0, 8'h00, 1'b1, m[k]);
		end
		ix(`PORT_GFX_INDEX, {4'h0, `GFX_MODE}, 8'h08);
		for (int t = 0; t < 5; t++)
		begin
			c = 8'($urandom) & 8'h0f;
			dc = 8'($urandom) & 8'h0f;
			ix(`PORT_GFX_INDEX, {4'h0, `GFX_COLOR_CMP}, c);
			ix(`PORT_GFX_INDEX, {4'h0, `GFX_DONT_CARE}, dc);
			mem(20'ha0010, 1'b0, 8'h00, 1'b1, cmp(c[3:0], dc[3:0]));
		end
		ix(`PORT_GFX_INDEX, {4'h0, `GFX_MODE}, 8'h00);
		io(`PORT_LK_WRITE_INDEX, 1'b1, 8'h00, 8'h00);
		for (int i = 0; i < 256; i++)
		begin
			lut[i] = 18'($urandom);
			for (int j = 2; j >= 0; j--)
				io(`PORT_LK_DATA, 1'b1, {2'b00, lut[i][j*6 +: 6]}, 8'h00);
		end
		io(`PORT_LK_READ_INDEX, 1'b1, 8'h05, 8'h00);
		for (int j = 2; j >= 0; j--)
			io(`PORT_LK_DATA, 1'b0, 8'h00, {2'b00, lut[5][j*6 +: 6]});
		for (int i = 0; i < 16; i++)
			attr_wr(8'(i), 8'(15 - i));
		attr_wr(`ATTR_MODE, 8'h00);
		show(16'h0010, 8, FMT_PLANAR16);
		m[0] = 8'h53;
		m[2] = 8'h3c;
		load_maps(20'h00020);
		attr_wr(`ATTR_MODE, 8'h02);
		show(16'h0020, 8, FMT_MONO);
		attr_wr(`ATTR_MODE, 8'h00);
		attr_wr(`ATTR_PLANE_EN, 8'h01);
		show(16'h0020, 8, FMT_TWO);
		attr_wr(`ATTR_PLANE_EN, `PLANE_EN_RESET);
		ix(`PORT_SEQ_INDEX, {5'h00, `SEQ_MEM_MODE}, 8'h08);
		for (int k = 0; k < 4; k++)
		begin
			m[k] = 8'($urandom);
			mem(20'ha0040 + 20'(k), 1'b1, m[k], 1'b1, 8'h00);
		end
		mem(20'ha0042, 1'b0, 8'h00, 1'b1, m[2]);
		ix(`PORT_GFX_INDEX, {4'h0, `GFX_MODE}, 8'h40);
		show(16'h0010, 4, FMT_PACKED256);
		end_sim();
	end
endmodule // planar_video_memory_access_bench
